/* core/phy_rst_pkg.sv */
// Shared constants and types for the transceiver reset sequencer
package phy_rst_pkg;
  localparam logic [15:0] OFF_DEVICE_CONTROL     = 16'h0000;
  localparam logic [15:0] OFF_NVM_MGMT_CONTROL   = 16'h1010;
  localparam logic [15:0] OFF_MANAGEMENT_CONTROL = 16'h5820;
  localparam logic [15:0] OFF_SEMAPHORE_FLAGS    = 16'h5b50;
  localparam logic [15:0] OFF_IRQ_STATUS         = 16'h6000;
  localparam logic [15:0] OFF_IRQ_ENABLE         = 16'h6004;
  localparam logic [15:0] OFF_IRQ_CLEAR          = 16'h6008;
  localparam logic [15:0] OFF_MODE               = 16'h600c;

  localparam int BIT_PHY_RESET     = 31;
  localparam int BIT_CONFIG_DONE   = 18;
  localparam int BIT_RESET_BLOCK   = 18;
  localparam int BIT_THREAD_SEM    = 0;
  localparam int BIT_FIRMWARE_SEM  = 1;
  localparam int BIT_PORT0_IND     = 0;
  localparam int BIT_PORT1_IND     = 1;
  localparam int BIT_CFG_DONE_EVT  = 2;
  localparam int BIT_MODE_INBAND   = 0;
  localparam int BIT_MODE_PORT     = 1;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  localparam int CLK_MHZ        = 125;
  localparam int RESET_HOLD_US  = 100;
  localparam int SETTLE_MS      = 1;
  localparam int CFG_LOAD_NS    = 2000;
  localparam int CFG_LOAD_CYC   = (CFG_LOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int MSG_BITS       = 8;
  localparam logic [7:0] RESET_MSG = 8'ha5;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } addr_beat_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic [3:0]  strb;
  } data_beat_t;
endpackage

/* core/phy_rst_msg_tx.sv */
// Serialiser that sends the in-band reset message to one transceiver port
`timescale 1ns/1ps
module phy_rst_msg_tx #(
  parameter int MSG_W = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_start,
  input  wire logic [MSG_W-1:0] i_msg,
  output logic                  o_bit,
  output logic                  o_frame,
  output logic                  o_busy
);
  logic [MSG_W-1:0] shift_reg;
  logic [7:0]       cnt_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      shift_reg <= '0;
      cnt_reg   <= 8'h00;
      o_bit     <= 1'b0;
      o_frame   <= 1'b0;
      o_busy    <= 1'b0;
    end else if (i_start && !o_busy) begin
      shift_reg <= i_msg;
      cnt_reg   <= 8'(MSG_W);
      o_busy    <= 1'b1;
      o_frame   <= 1'b0;
    end else if (cnt_reg != 8'h00) begin
      o_bit     <= shift_reg[MSG_W-1];
      o_frame   <= 1'b1;
      shift_reg <= {shift_reg[MSG_W-2:0], 1'b0};
      cnt_reg   <= cnt_reg - 8'h01;
    end else begin
      o_bit   <= 1'b0;
      o_frame <= 1'b0;
      o_busy  <= 1'b0;
    end
  end
endmodule

/* core/phy_reset_sequencing.sv */
// Transceiver reset sequencer with AXI4-Lite register slave
// Operation
// - Reset pin asserted while request bit set, in out-of-band mode only
// - Device sets config-done after post-reset load
// - In-band mode sends reset message on link
// - In-band mode flags port and interrupts firmware
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module phy_reset_sequencing
  import phy_rst_pkg::*;
#(
  parameter int CFG_LOAD_CYCLES = CFG_LOAD_CYC
) (
  input  wire logic                 I_CLK,
  input  wire logic                 I_SRST,
  input  wire logic                 I_AWVALID,
  output logic                      O_AWREADY,
  input  wire logic [15:0]          I_AWADDR,
  input  wire logic                 I_WVALID,
  output logic                      O_WREADY,
  input  wire logic [31:0]          I_WDATA,
  input  wire logic [3:0]           I_WSTRB,
  output logic                      O_BVALID,
  input  wire logic                 I_BREADY,
  output logic [1:0]                O_BRESP,
  input  wire logic                 I_ARVALID,
  output logic                      O_ARREADY,
  input  wire logic [15:0]          I_ARADDR,
  output logic                      O_RVALID,
  input  wire logic                 I_RREADY,
  output logic [31:0]               O_RDATA,
  output logic [1:0]                O_RRESP,
  input  wire logic                 I_RESET_BLOCK,
  output logic                      O_PHY_RESET,
  output logic                      O_LINK_BIT,
  output logic                      O_LINK_FRAME,
  output logic                      O_IRQ
);
  import phy_rst_pkg::*;

  typedef enum logic [2:0] {
    CFG_IDLE  = 3'b001,
    CFG_RESET = 3'b010,
    CFG_LOAD  = 3'b100
  } cfg_state_t;

  // Write and read channel capture; write address and data may arrive in either order
  addr_beat_t aw_reg;
  data_beat_t w_reg;
  addr_beat_t ar_reg;

  logic        phy_rst_reg;
  logic [1:0]  sem_reg;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_enable_reg;
  logic [1:0]  mode_reg;
  logic        cfg_done_reg;
  logic [31:0] load_cnt_reg;
  cfg_state_t  cfg_state_reg;
  cfg_state_t  cfg_state_next;
  logic        blk_s1_reg;
  logic        blk_s2_reg;
  logic        blk_s3_reg;
  logic        blk_reg;
  logic        msg_start_reg;

  wire msg_bit;
  wire msg_frame;
  wire msg_busy;

  // Reset-block flag comes from the management block, outside this clock
  // A level counts only once the second and third stages agree, so a glitch sampled for one cycle is never seen
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      blk_s1_reg <= 1'b0;
      blk_s2_reg <= 1'b0;
      blk_s3_reg <= 1'b0;
      blk_reg    <= 1'b0;
    end else begin
      blk_s1_reg <= I_RESET_BLOCK;
      blk_s2_reg <= blk_s1_reg;
      blk_s3_reg <= blk_s2_reg;
      if (blk_s2_reg == blk_s3_reg) begin
        blk_reg <= blk_s3_reg;
      end
    end
  end

  // Word-aligned decode shared by the write and read paths; low address bits are ignored
  function automatic logic [15:0] word_addr(input logic [15:0] a);
    word_addr = a & 16'hfffc;
  endfunction

  // Unmapped words answer SLVERR so a driver with a wrong base address finds out at once
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a == OFF_DEVICE_CONTROL) || (a == OFF_SEMAPHORE_FLAGS)
             || (a == OFF_IRQ_ENABLE) || (a == OFF_IRQ_CLEAR)
             || (a == OFF_MODE) || (a == OFF_NVM_MGMT_CONTROL)
             || (a == OFF_MANAGEMENT_CONTROL) || (a == OFF_IRQ_STATUS);
  endfunction

  // Channel handshakes: one item moves at an edge with valid and ready both high
  wire        aw_take   = I_AWVALID && O_AWREADY;
  wire        w_take    = I_WVALID && O_WREADY;
  wire        ar_take   = I_ARVALID && O_ARREADY;
  wire        b_done    = O_BVALID && I_BREADY;
  wire        r_done    = O_RVALID && I_RREADY;

  // Bus decode
  wire        wr_go     = aw_reg.valid && w_reg.valid && !O_BVALID;
  wire [15:0] wr_addr   = word_addr(aw_reg.addr);
  wire [31:0] wr_data   = w_reg.data;
  wire        wr_strb3  = w_reg.strb[3];
  wire        wr_strb0  = w_reg.strb[0];
  wire        wr_ctrl   = wr_go && (wr_addr == OFF_DEVICE_CONTROL);
  wire        wr_sem    = wr_go && (wr_addr == OFF_SEMAPHORE_FLAGS) && wr_strb0;
  wire        wr_ien    = wr_go && (wr_addr == OFF_IRQ_ENABLE) && wr_strb0;
  wire        wr_iclr   = wr_go && (wr_addr == OFF_IRQ_CLEAR) && wr_strb0;
  wire        wr_mode   = wr_go && (wr_addr == OFF_MODE) && wr_strb0;
  wire        wr_known  = is_mapped(wr_addr);
  wire        phy_rst_next = (wr_ctrl && wr_strb3) ? wr_data[BIT_PHY_RESET] : phy_rst_reg;
  wire        rst_rise  = phy_rst_next && !phy_rst_reg;

  wire        rd_go     = ar_reg.valid && !O_RVALID;
  wire [15:0] rd_addr   = word_addr(ar_reg.addr);
  wire        rd_known  = is_mapped(rd_addr);
  // Status words show live state; the clear register always reads as zero
  wire [31:0] rd_data =
      (rd_addr == OFF_DEVICE_CONTROL)     ? (32'(phy_rst_reg) << BIT_PHY_RESET) :
      (rd_addr == OFF_NVM_MGMT_CONTROL)   ? (32'(cfg_done_reg) << BIT_CONFIG_DONE) :
      (rd_addr == OFF_MANAGEMENT_CONTROL) ? (32'(blk_reg) << BIT_RESET_BLOCK) :
      (rd_addr == OFF_SEMAPHORE_FLAGS)    ? {30'h0, sem_reg} :
      (rd_addr == OFF_IRQ_STATUS)         ? {29'h0, irq_status_reg} :
      (rd_addr == OFF_IRQ_ENABLE)         ? {29'h0, irq_enable_reg} :
      (rd_addr == OFF_MODE)               ? {30'h0, mode_reg} : RST_ZERO;

  // Configuration-load sequencing after a transceiver reset
  // The load timer runs only in CFG_LOAD, so a fresh reset restarts it from zero
  wire load_done = (load_cnt_reg >= 32'(CFG_LOAD_CYCLES - 1));
  always_comb begin
    cfg_state_next = cfg_state_reg;
    unique case (cfg_state_reg)
      CFG_IDLE:  if (phy_rst_reg) cfg_state_next = CFG_RESET;
      CFG_RESET: if (!phy_rst_reg) cfg_state_next = CFG_LOAD;
      CFG_LOAD: begin
        if (phy_rst_reg) cfg_state_next = CFG_RESET;
        else if (load_done) cfg_state_next = CFG_IDLE;
      end
      default:   cfg_state_next = CFG_IDLE;
    endcase
  end

  wire cfg_finish = (cfg_state_reg == CFG_LOAD) && load_done && !phy_rst_reg;
  wire inband     = mode_reg[BIT_MODE_INBAND];
  wire [2:0] irq_set = {cfg_finish,
                        rst_rise && inband && mode_reg[BIT_MODE_PORT],
                        rst_rise && inband && !mode_reg[BIT_MODE_PORT]};
  wire [2:0] irq_clr = wr_iclr ? wr_data[2:0] : 3'b000;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cfg_state_reg <= CFG_IDLE;
      load_cnt_reg  <= RST_ZERO;
      cfg_done_reg  <= 1'b1;
    end else begin
      cfg_state_reg <= cfg_state_next;
      load_cnt_reg  <= (cfg_state_reg == CFG_LOAD) ? load_cnt_reg + 32'h1 : RST_ZERO;
      if (phy_rst_reg) begin
        cfg_done_reg <= 1'b0;
      end else if (cfg_finish) begin
        cfg_done_reg <= 1'b1;
      end
    end
  end

  // Write channels; address and data are captured apart, the response follows both
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      aw_reg    <= '0;
      w_reg     <= '0;
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= RESP_OKAY;
    end else begin
      O_AWREADY <= !aw_reg.valid && !O_AWREADY && I_AWVALID;
      O_WREADY  <= !w_reg.valid && !O_WREADY && I_WVALID;
      if (aw_take) begin
        aw_reg <= '{valid: 1'b1, addr: I_AWADDR};
      end
      if (w_take) begin
        w_reg <= '{valid: 1'b1, data: I_WDATA, strb: I_WSTRB};
      end
      if (wr_go) begin
        O_BVALID     <= 1'b1;
        O_BRESP      <= wr_known ? RESP_OKAY : RESP_SLVERR;
        aw_reg.valid <= 1'b0;
        w_reg.valid  <= 1'b0;
      end else if (b_done) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // Read channels; the data word is sampled once the address has been captured
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ar_reg    <= '0;
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= RST_ZERO;
      O_RRESP   <= RESP_OKAY;
    end else begin
      O_ARREADY <= !ar_reg.valid && !O_ARREADY && I_ARVALID;
      if (ar_take) begin
        ar_reg <= '{valid: 1'b1, addr: I_ARADDR};
      end
      if (rd_go) begin
        O_RVALID     <= 1'b1;
        O_RDATA      <= rd_data;
        O_RRESP      <= rd_known ? RESP_OKAY : RESP_SLVERR;
        ar_reg.valid <= 1'b0;
      end else if (r_done) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // Software-visible control registers
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      phy_rst_reg    <= 1'b0;
      sem_reg        <= 2'b00;
      irq_enable_reg <= 3'b000;
      mode_reg       <= 2'b00;
    end else begin
      phy_rst_reg <= phy_rst_next;
      // Semaphores are plain storage; ownership discipline is software's job
      if (wr_sem) begin
        sem_reg <= wr_data[1:0];
      end
      if (wr_ien) begin
        irq_enable_reg <= wr_data[2:0];
      end
      if (wr_mode) begin
        mode_reg <= wr_data[1:0];
      end
    end
  end

  // Interrupt status and the level output
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      irq_status_reg <= 3'b000;
      O_IRQ          <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      O_IRQ          <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // Reset pin and in-band message request
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      msg_start_reg <= 1'b0;
      O_PHY_RESET   <= 1'b0;
    end else begin
      // Out-of-band mode drives the pin; in-band mode sends a message instead
      O_PHY_RESET   <= phy_rst_reg && !inband;
      // A request raised while a frame is on the link waits until the link is free
      msg_start_reg <= (rst_rise && inband) || (msg_start_reg && msg_busy);
    end
  end

  // Link serialiser; it takes a start only while idle
  phy_rst_msg_tx #(
    .MSG_W (MSG_BITS)
  ) u_msg_tx (
    .i_clk   (I_CLK),
    .i_srst  (I_SRST),
    .i_start (msg_start_reg),
    .i_msg   (RESET_MSG),
    .o_bit   (msg_bit),
    .o_frame (msg_frame),
    .o_busy  (msg_busy)
  );

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_LINK_BIT   <= 1'b0;
      O_LINK_FRAME <= 1'b0;
    end else begin
      O_LINK_BIT   <= msg_bit;
      O_LINK_FRAME <= msg_frame;
    end
  end
endmodule

/* dv/phy_reset_sequencing_asserts.sv */
// Port timing checker for the transceiver reset sequencer
`timescale 1ns/1ps
module phy_reset_sequencing_asserts
  import phy_rst_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic O_AWREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic O_PHY_RESET,
  input wire logic O_LINK_BIT,
  input wire logic O_LINK_FRAME,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence frame_start;
    $rose(O_LINK_FRAME);
  endsequence
  sequence frame_body;
    O_LINK_FRAME [*8] ##1 !O_LINK_FRAME;
  endsequence
  AST_FRAME_LEN: assert property (frame_start |-> frame_body)
    else $error("link frame length wrong");
  AST_FRAME_MSB: assert property (frame_start |-> O_LINK_BIT == RESET_MSG[7])
    else $error("link frame first bit wrong");
  AST_NO_FRAME_IN_RST: assert property (!(O_PHY_RESET && O_LINK_FRAME))
    else $error("frame sent while reset pin high");
  AST_RST_FROM_WRITE: assert property ($changed(O_PHY_RESET) |-> $past(O_BVALID))
    else $error("reset pin moved without a register write");
  AST_IRQ_CLEAR: assert property ($fell(O_IRQ) |-> $past(O_BVALID) || $past(O_BVALID, 2))
    else $error("interrupt dropped without a register write");
  AST_AW_PULSE: assert property (O_AWREADY |=> !O_AWREADY)
    else $error("write address ready longer than one cycle");
  AST_B_DONE: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response repeated");
  AST_R_DONE: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read response repeated");
endmodule

bind phy_reset_sequencing phy_reset_sequencing_asserts u_chk (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .O_AWREADY(O_AWREADY), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .O_PHY_RESET(O_PHY_RESET), .O_LINK_BIT(O_LINK_BIT), .O_LINK_FRAME(O_LINK_FRAME),
  .O_IRQ(O_IRQ)
);

/* dv/phy_xcvr_model.sv */
// Behavioural transceiver: counts reset cycles and collects in-band messages
`timescale 1ns/1ps
module phy_xcvr_model (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_phy_reset,
  input  wire logic       i_bit,
  input  wire logic       i_frame,
  output logic      [7:0] o_msg,
  output int              o_n_msg,
  output int              o_rst_cyc
);
  logic [7:0] shift_reg;
  logic       frame_reg;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_n_msg   <= 0;
      o_rst_cyc <= 0;
      frame_reg <= 1'b0;
    end else begin
      frame_reg <= i_frame;
      if (i_phy_reset) o_rst_cyc <= o_rst_cyc + 1;
      if (i_frame) shift_reg <= {shift_reg[6:0], i_bit};
      // Byte is taken when the frame closes, so a short frame shows as a wrong byte
      if (frame_reg && !i_frame) begin
        o_msg   <= shift_reg;
        o_n_msg <= o_n_msg + 1;
      end
    end
  end
endmodule

/* dv/phy_reset_sequencing_bench.sv */
// Self-checking bench for the transceiver reset sequencer
`timescale 1ns/1ps
module phy_reset_sequencing_bench;
  import phy_rst_pkg::*;
  localparam int CFG_CYC  = 4;
  localparam int HOLD_CYC = RESET_HOLD_US * CLK_MHZ;
  // Settling is a software wait only; shortened to keep the run brief
  localparam int SETTLE_CYC = SETTLE_MS * CLK_MHZ * 1000 / 16;
  localparam logic [15:0] ZOFF [7] = '{OFF_DEVICE_CONTROL, OFF_MANAGEMENT_CONTROL,
    OFF_SEMAPHORE_FLAGS, OFF_IRQ_STATUS, OFF_IRQ_ENABLE, OFF_IRQ_CLEAR, OFF_MODE};
  logic        clk = 0, srst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, rblk = 0;
  logic [15:0] awa = '0, ara = '0;
  logic [3:0]  ws = 4'hf;
  logic [31:0] wd = '0, d, rdat;
  logic [1:0]  r, bresp_w, rresp_w;
  logic        awrdy, wrdy, bval, arrdy, rval, phy_rst, lbit, lframe, irq;
  logic [7:0]  msg;
  int          n_fail = 0, n_checks = 0, n_msg, rst_cyc;
  phy_reset_sequencing #(.CFG_LOAD_CYCLES(CFG_CYC)) u_dut (
    .I_CLK(clk), .I_SRST(srst), .I_AWVALID(awv), .O_AWREADY(awrdy), .I_AWADDR(awa),
    .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bval),
    .I_BREADY(br), .O_BRESP(bresp_w), .I_ARVALID(arv), .O_ARREADY(arrdy),
    .I_ARADDR(ara), .O_RVALID(rval), .I_RREADY(rr), .O_RDATA(rdat), .O_RRESP(rresp_w),
    .I_RESET_BLOCK(rblk), .O_PHY_RESET(phy_rst), .O_LINK_BIT(lbit),
    .O_LINK_FRAME(lframe), .O_IRQ(irq));
  phy_xcvr_model u_phy (.i_clk(clk), .i_srst(srst), .i_phy_reset(phy_rst), .i_bit(lbit),
    .i_frame(lframe), .o_msg(msg), .o_n_msg(n_msg), .o_rst_cyc(rst_cyc));
  always #4 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    awv <= 1'b1;
    wv  <= 1'b1;
    awa <= a;
    wd  <= v;
    br  <= 1'b1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bval);
    r = bresp_w;
    br <= 1'b0;
  endtask
  task automatic rdr(input logic [15:0] a);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr  <= 1'b1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
    end while (!rval);
    d = rdat;
    r = rresp_w;
    rr <= 1'b0;
  endtask
  task automatic wait_cfg;
    do rdr(OFF_NVM_MGMT_CONTROL); while (d[BIT_CONFIG_DONE] !== 1'b1);
  endtask
  task automatic t_reset_values;
    for (int i = 0; i < 7; i++) begin
      rdr(ZOFF[i]);
      chk(d, RST_ZERO);
    end
    rdr(OFF_NVM_MGMT_CONTROL);
    chk(d[BIT_CONFIG_DONE], 1'b1);
    rdr(16'h0ffc);
    chk(r, RESP_SLVERR);
    chk(d, RST_ZERO);
    wr(16'h0ffc, 32'h1);
    chk(r, RESP_SLVERR);
  endtask
  task automatic t_strobes;
    ws <= 4'h7;
    wr(OFF_DEVICE_CONTROL, 32'h8000_0000);
    ws <= 4'hf;
    chk(r, RESP_OKAY);
    rdr(OFF_DEVICE_CONTROL);
    chk(d, RST_ZERO);
    chk(phy_rst, 1'b0);
    ws <= 4'h8;
    wr(OFF_SEMAPHORE_FLAGS, 32'h3);
    ws <= 4'hf;
    rdr(OFF_SEMAPHORE_FLAGS);
    chk(d, RST_ZERO);
    wr(OFF_NVM_MGMT_CONTROL, RST_ZERO);
    rdr(OFF_NVM_MGMT_CONTROL);
    chk(d, 32'h1 << BIT_CONFIG_DONE);
  endtask
  task automatic t_sw_reset;
    wr(OFF_SEMAPHORE_FLAGS, 32'h1);
    rblk <= 1'b1;
    repeat (6) @(posedge clk);
    rdr(OFF_MANAGEMENT_CONTROL);
    chk(d[BIT_RESET_BLOCK], 1'b1);
    rblk <= 1'b0;
    do rdr(OFF_MANAGEMENT_CONTROL); while (d[BIT_RESET_BLOCK] !== 1'b0);
    wr(OFF_SEMAPHORE_FLAGS, 32'h3);
    wr(OFF_IRQ_ENABLE, 32'h4);
    wr(OFF_DEVICE_CONTROL, 32'h8000_0000);
    rdr(OFF_NVM_MGMT_CONTROL);
    chk(d[BIT_CONFIG_DONE], 1'b0);
    chk(phy_rst, 1'b1);
    repeat (HOLD_CYC) @(posedge clk);
    wr(OFF_DEVICE_CONTROL, RST_ZERO);
    wr(OFF_SEMAPHORE_FLAGS, 32'h1);
    chk(phy_rst, 1'b0);
    chk(rst_cyc >= HOLD_CYC, 1'b1);
    wait_cfg;
    rdr(OFF_IRQ_STATUS);
    chk(d, 32'h4);
    chk(irq, 1'b1);
    repeat (SETTLE_CYC) @(posedge clk);
    wr(OFF_IRQ_CLEAR, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(OFF_SEMAPHORE_FLAGS, 32'h3);
    rdr(OFF_SEMAPHORE_FLAGS);
    chk(d, 32'h3);
    wr(OFF_SEMAPHORE_FLAGS, 32'h1);
    wr(OFF_SEMAPHORE_FLAGS, RST_ZERO);
    rdr(OFF_SEMAPHORE_FLAGS);
    chk(d, RST_ZERO);
  endtask
  task automatic t_inband;
    int n0;
    wr(OFF_IRQ_ENABLE, 32'h3);
    for (int p = 0; p < 2; p++) begin
      n0 = n_msg;
      wr(OFF_MODE, {30'h0, p[0], 1'b1});
      wr(OFF_DEVICE_CONTROL, 32'h8000_0000);
      do @(posedge clk); while (n_msg == n0);
      chk(msg, RESET_MSG);
      chk(phy_rst, 1'b0);
      rdr(OFF_IRQ_STATUS);
      chk(d[1:0], p ? 2'b11 : 2'b01);
      chk(irq, 1'b1);
      wr(OFF_DEVICE_CONTROL, RST_ZERO);
    end
    wr(OFF_IRQ_ENABLE, RST_ZERO);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wait_cfg;
    wr(OFF_IRQ_CLEAR, 32'h7);
    rdr(OFF_IRQ_STATUS);
    chk(d, RST_ZERO);
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset_values;
    t_strobes;
    t_sw_reset;
    t_inband;
    final_report;
  end
endmodule
